// [hw/bds_map.vh]
// Register offsets, field positions, event codes and reset values of the event selector
`ifndef BDS_MAP_VH
`define BDS_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define BDS_OFF_CTRL 8'h00
`define BDS_OFF_COUNT 8'h04
`define BDS_OFF_STATUS 8'h08

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BDS_CTRL_CODE_LSB 0
`define BDS_CTRL_MASK_LSB 8
`define BDS_CTRL_EN_BIT 16
`define BDS_CTRL_THR_LSB 24
`define BDS_CTRL_RST 32'h00000000
`define BDS_COUNT_RST 32'h00000000

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define BDS_ST_OVF_BIT 0
`define BDS_ST_INC_LSB 8
`define BDS_ST_EN_BIT 16

// ----------------------------------------
// Event codes
// ----------------------------------------
`define BDS_EV_BR_EXEC 8'h88
`define BDS_EV_BR_MISP 8'h89
`define BDS_EV_UNDELIV 8'h9C
`define BDS_EV_DISPATCH 8'hA1
`define BDS_EV_STALL 8'hA2
`define BDS_EV_SWITCH 8'hAB

// ----------------------------------------
// Unit-select values and bit positions
// ----------------------------------------
`define BDS_UM_ALL 8'hFF
`define BDS_UM_UNDELIV 8'h01
`define BDS_UM_SWITCH 8'h01
`define BDS_UB_NOT_TAKEN 6
`define BDS_UB_TAKEN 7
`define BDS_UB_ST_ANY 0
`define BDS_UB_ST_RS 2
`define BDS_UB_ST_SB 3
`define BDS_UB_ST_ROB 4

`endif

// [hw/bds_branch_match.v]
// Branch qualifier: type and direction match for the executed-branch events
`timescale 1ns/1ps
`default_nettype none
`include "bds_map.vh"

module bds_branch_match (
  input wire [7:0] umask,
  input wire misp_only,
  input wire br_valid,
  input wire [5:0] br_type,
  input wire br_taken,
  input wire br_mispredicted,
  output wire hit
);

  wire any_type;
  wire dir_sel;
  wire dir_ok;
  wire all_sel;
  wire misp_ok;

  // ----------------------------------------
  // Type and direction
  // ----------------------------------------
  assign any_type = |(umask[5:0] & br_type); // RULE_21
  // No direction bit: type alone qualifies, a lenient reading of illegal masks
  assign dir_sel = umask[`BDS_UB_TAKEN] | umask[`BDS_UB_NOT_TAKEN];
  assign dir_ok = ~dir_sel
    | (umask[`BDS_UB_TAKEN] & br_taken) // RULE_06
    | (umask[`BDS_UB_NOT_TAKEN] & ~br_taken); // RULE_05
  assign all_sel = (umask == `BDS_UM_ALL); // RULE_07
  assign misp_ok = ~misp_only | br_mispredicted; // RULE_08
  assign hit = br_valid & misp_ok & (all_sel | (any_type & dir_ok)); // RULE_09

endmodule // bds_branch_match
`default_nettype wire

// [hw/bds_event_select.v]
// Performance event selector with APB-programmed code, unit mask, threshold and counter
`timescale 1ns/1ps
`default_nettype none
`include "bds_map.vh"

// What this block does
// RULE_01 - 88H/04H: indirect jumps, not calls or returns
// RULE_02 - 88H/08H: executed near returns
// RULE_03 - 88H/10H: direct near calls only
// RULE_04 - 88H/20H: indirect near calls, register or memory
// RULE_05 - 40H: not-taken branches, only with 01H
// RULE_06 - 80H: taken branches, needs a type bit
// RULE_07 - FFH under 88H/89H counts every branch
// RULE_08 - 89H: mispredicted only, same type bits
// RULE_09 - 89H direction bits as for 88H
// RULE_10 - 9CH/01H: undelivered slots per thread, summed
// RULE_11 - A1H: per-port dispatch cycles, ports 0,1,4,5
// RULE_12 - A1H 04H/08H: port 2 load, store-address
// RULE_13 - A1H 10H/20H/30H: port 3 load, store-address
// RULE_14 - A2H/01H: any resource stall cycle
// RULE_15 - A2H/04H: no reservation station entry
// RULE_16 - A2H/08H: store buffer full, not draining
// RULE_17 - A2H/10H: reorder buffer full cycles
// RULE_18 - ABH/01H: decode path switch count
// RULE_19 - Threshold one: count nonzero cycles instead
// RULE_20 - Every clock, add OR or sum
// RULE_21 - Any selected type and selected direction
module bds_event_select (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire br_valid,
  input wire br_cond,
  input wire br_direct_jmp,
  input wire br_indirect_jmp,
  input wire br_return,
  input wire br_direct_call,
  input wire br_indirect_call,
  input wire br_taken,
  input wire br_mispredicted,
  input wire [2:0] undelivered_slots,
  input wire disp_p0,
  input wire disp_p1,
  input wire disp_p2_load,
  input wire disp_p2_store_address_uop,
  input wire disp_p3_load,
  input wire disp_p3_store_address_uop,
  input wire disp_p4,
  input wire disp_p5,
  input wire stall_any,
  input wire stall_reservation_station,
  input wire stall_store_buffer,
  input wire stall_store_buffer_drain,
  input wire stall_reorder_buffer,
  input wire decode_path_switch,
  output wire [31:0] event_count,
  output wire [2:0] event_increment
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] ctrl_d;
  reg [31:0] count_q;
  reg [31:0] count_d;
  reg ovf_q;
  reg ovf_d;
  reg [2:0] inc_q;
  reg [2:0] inc_d;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg pslverr_q;
  reg pslverr_d;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire setup_ph;
  wire access_wr;
  wire hit_ctrl;
  wire hit_count;
  wire hit_status;
  wire mapped;
  wire wr_ctrl;
  wire wr_count;
  wire wr_status;

  // Zero-wait slave: read data is caught in the setup cycle
  assign setup_ph = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign hit_ctrl = (paddr == `BDS_OFF_CTRL);
  assign hit_count = (paddr == `BDS_OFF_COUNT);
  assign hit_status = (paddr == `BDS_OFF_STATUS);
  assign mapped = hit_ctrl | hit_count | hit_status;
  // Writes to unmapped offsets fall through every decode
  assign wr_ctrl = access_wr & hit_ctrl;
  assign wr_count = access_wr & hit_count;
  assign wr_status = access_wr & hit_status;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  wire [7:0] ev_code;
  wire [7:0] umask;
  wire enable;
  wire [7:0] threshold;

  assign ev_code = ctrl_q[`BDS_CTRL_CODE_LSB +: 8];
  assign umask = ctrl_q[`BDS_CTRL_MASK_LSB +: 8];
  assign enable = ctrl_q[`BDS_CTRL_EN_BIT];
  assign threshold = ctrl_q[`BDS_CTRL_THR_LSB +: 8];

  // ----------------------------------------
  // Branch events
  // ----------------------------------------
  wire [5:0] br_type;
  wire is_br_exec;
  wire is_br_misp;
  wire br_hit;

  // Bit order follows the unit-select type bits 01H..20H
  assign br_type = {
    br_indirect_call, // RULE_04
    br_direct_call, // RULE_03
    br_return, // RULE_02
    br_indirect_jmp, // RULE_01
    br_direct_jmp,
    br_cond
  };
  assign is_br_exec = (ev_code == `BDS_EV_BR_EXEC);
  assign is_br_misp = (ev_code == `BDS_EV_BR_MISP);

  bds_branch_match u_branch (
    .umask(umask),
    .misp_only(is_br_misp),
    .br_valid(br_valid),
    .br_type(br_type),
    .br_taken(br_taken),
    .br_mispredicted(br_mispredicted),
    .hit(br_hit)
  );

  // ----------------------------------------
  // Dispatch and stall strobes
  // ----------------------------------------
  wire [7:0] disp_vec;
  wire [7:0] stall_vec;
  wire [7:0] disp_hit;
  wire [7:0] stall_hit;

  assign disp_vec = {
    disp_p5,
    disp_p4,
    disp_p3_store_address_uop,
    disp_p3_load,
    disp_p2_store_address_uop,
    disp_p2_load,
    disp_p1,
    disp_p0
  };

  // Drain for synchronisation is masked out of the store buffer stall
  assign stall_vec = {
    3'h0,
    stall_reorder_buffer, // RULE_17
    stall_store_buffer & ~stall_store_buffer_drain, // RULE_16
    stall_reservation_station, // RULE_15
    1'b0,
    stall_any // RULE_14
  };

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      assign disp_hit[gi] = umask[gi] & disp_vec[gi]; // RULE_11
      assign stall_hit[gi] = umask[gi] & stall_vec[gi];
    end
  endgenerate

  // ----------------------------------------
  // Event selection
  // ----------------------------------------
  reg [2:0] sel_count;

  always @* begin
    sel_count = 3'h0;
    case (ev_code)
      `BDS_EV_BR_EXEC: begin
        sel_count = {2'h0, br_hit & is_br_exec}; // RULE_20
      end
      `BDS_EV_BR_MISP: begin
        sel_count = {2'h0, br_hit & is_br_misp}; // RULE_08
      end
      `BDS_EV_UNDELIV: begin
        if (umask == `BDS_UM_UNDELIV) begin
          sel_count = undelivered_slots; // RULE_10
        end
      end
      `BDS_EV_DISPATCH: begin
        // Port 2 and 3 share one cycle: 0CH and 30H give an OR, not a sum
        sel_count = {2'h0, |disp_hit}; // RULE_12 RULE_13
      end
      `BDS_EV_STALL: begin
        sel_count = {2'h0, |stall_hit};
      end
      `BDS_EV_SWITCH: begin
        if (umask == `BDS_UM_SWITCH) begin
          sel_count = {2'h0, decode_path_switch}; // RULE_18
        end
      end
      default: begin
        sel_count = 3'h0;
      end
    endcase
  end

  // ----------------------------------------
  // Threshold
  // ----------------------------------------
  wire thr_zero;
  wire sel_ge;
  wire [2:0] add_val;

  // Zero threshold adds the count; otherwise one per qualifying cycle
  assign thr_zero = (threshold == 8'h00);
  assign sel_ge = ({5'h00, sel_count} >= threshold);
  assign add_val = thr_zero ? sel_count : {2'h0, sel_ge}; // RULE_19

  // ----------------------------------------
  // Counter and overflow
  // ----------------------------------------
  wire [32:0] sum;
  wire wrap;

  assign sum = {1'b0, count_q} + {30'h0, add_val};
  // A preset discards the increment, so it cannot wrap either
  assign wrap = enable & sum[32] & ~wr_count;

  always @* begin
    count_d = count_q;
    ovf_d = ovf_q;
    if (enable) begin
      count_d = sum[31:0]; // RULE_20
    end
    // A software preset wins over a same-cycle increment
    if (wr_count) begin
      count_d = pwdata;
    end
    // Write one clears; a same-cycle wrap still sets
    if (wr_status & pwdata[`BDS_ST_OVF_BIT]) begin
      ovf_d = 1'b0;
    end
    if (wrap) begin
      ovf_d = 1'b1;
    end
  end

  // ----------------------------------------
  // Control and increment next values
  // ----------------------------------------
  // A new setting applies from the edge after the write
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = pwdata;
    end
    // Disabled counting reports a zero increment
    inc_d = 3'h0;
    if (enable) begin
      inc_d = add_val; // RULE_20
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  reg [31:0] status_word;

  // Bits outside the three fields read as zero
  always @* begin
    status_word = 32'h00000000;
    status_word[`BDS_ST_OVF_BIT] = ovf_q;
    status_word[`BDS_ST_INC_LSB +: 3] = inc_q;
    status_word[`BDS_ST_EN_BIT] = enable;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_ph) begin
      prdata_d = 32'h00000000;
      pslverr_d = ~mapped;
      if (~pwrite & hit_ctrl) begin
        prdata_d = ctrl_q;
      end
      if (~pwrite & hit_count) begin
        prdata_d = count_q;
      end
      if (~pwrite & hit_status) begin
        prdata_d = status_word;
      end
    end
  end

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BDS_CTRL_RST;
      count_q <= `BDS_COUNT_RST;
      ovf_q <= 1'b0;
      inc_q <= 3'h0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      ovf_q <= ovf_d;
      inc_q <= inc_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign event_count = count_q;
  assign event_increment = inc_q;

endmodule // bds_event_select
`default_nettype wire

// [bench/bds_core_model.sv]
// Core pipeline model driving the event strobes
`timescale 1ns/1ps
`default_nettype none
module bds_core_model (
  input wire logic clk,
  input wire logic [25:0] vec,
  output logic [25:0] ev
);
  logic sw_q = 1'b0;
  // ----
  // Strobes
  // ----
  always @(posedge clk) begin
    sw_q <= vec[25];
  end
  // Type bits only mean something beside a valid branch
  always_comb begin
    ev = vec;
    if (!vec[0]) begin
      ev[8:1] = 8'h00;
    end
    ev[25] = vec[25] & ~sw_q;
  end
endmodule // bds_core_model
`default_nettype wire

// [bench/bds_event_select_props.sv]
// Port-level assertions for the event selector
`timescale 1ns/1ps
`default_nettype none
module bds_event_select_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic br_mispredicted,
  input wire logic [2:0] undelivered_slots,
  input wire logic stall_store_buffer_drain,
  input wire logic stall_reorder_buffer,
  input wire logic decode_path_switch,
  input wire logic [31:0] event_count,
  input wire logic [2:0] event_increment
);
  logic [31:0] ctrl_q;
  wire wr = psel && penable && pwrite;
  wire run = ctrl_q[16] && ctrl_q[31:24] == 8'h00;
  wire [15:0] sel = ctrl_q[15:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Shadow of the control word
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h00000000;
    end else if (wr && paddr == 8'h00) begin
      ctrl_q <= pwdata;
    end
  end
  // ----
  // Checks
  // ----
  a_count_adds: assert property (!(wr && paddr == 8'h04)
    |=> event_count == $past(event_count) + {29'h0, event_increment}) else $error("bad step");
  a_off_idle: assert property (!ctrl_q[16] |=> event_increment == 3'h0)
    else $error("count while off");
  a_unknown_zero: assert property (ctrl_q[16] && ctrl_q[7:0] == 8'h00
    |=> event_increment == 3'h0) else $error("unknown code counted");
  a_undeliv_sum: assert property (run && sel == 16'h019C
    |=> event_increment == $past(undelivered_slots)) else $error("slot sum wrong");
  a_thr_one: assert property (ctrl_q[16] && ctrl_q[31:24] == 8'h01 && sel == 16'h019C
    |=> event_increment == {2'b00, $past(undelivered_slots) != 3'h0}) else $error("thr one");
  a_drain_skip: assert property (run && sel == 16'h08A2 && stall_store_buffer_drain
    |=> event_increment == 3'h0) else $error("drain counted");
  a_rob_full: assert property (run && sel == 16'h10A2
    |=> event_increment == {2'b00, $past(stall_reorder_buffer)}) else $error("rob stall");
  a_switch_count: assert property (run && sel == 16'h01AB
    |=> event_increment == {2'b00, $past(decode_path_switch)}) else $error("switch");
  a_misp_only: assert property (ctrl_q[16] && ctrl_q[7:0] == 8'h89 && !br_mispredicted
    |=> event_increment == 3'h0) else $error("good branch counted");
  c_switch: cover property (run && sel == 16'h01AB && decode_path_switch);
  c_wrap: cover property (event_count == 32'h00000000 && $past(event_count) == 32'hFFFFFFFF);
  c_five: cover property (event_increment == 3'h5);
endmodule // bds_event_select_props
bind bds_event_select bds_event_select_props u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .br_mispredicted,
  .undelivered_slots, .stall_store_buffer_drain, .stall_reorder_buffer,
  .decode_path_switch, .event_count, .event_increment
);
`default_nettype wire

// [bench/bds_event_select_tb.sv]
// Self-checking bench for the event selector
`timescale 1ns/1ps
`default_nettype none
module bds_event_select_tb;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, exp_cnt;
  logic [25:0] vec;
  wire [25:0] ev;
  wire [31:0] prdata, event_count;
  wire pready, pslverr;
  wire [2:0] event_increment;
  int fails, checks_done;
  // Rows: code, unit select, threshold, strobes, increment
  logic [55:0] rows [0:45] = '{
    56'h88_84_00_0000089_1, 56'h88_84_00_0000091_0, 56'h88_84_00_0000009_0,
    56'h88_88_00_0000091_1, 56'h88_90_00_00000A1_1, 56'h88_90_00_0000085_0,
    56'h88_A0_00_00000C1_1, 56'h88_41_00_0000003_1, 56'h88_41_00_0000083_0,
    56'h88_FF_00_0000005_1, 56'h89_FF_00_0000111_1, 56'h89_FF_00_0000011_0,
    56'h89_81_00_0000083_0, 56'h89_81_00_0000183_1, 56'h89_41_00_0000103_1,
    56'h9C_01_00_0000A00_5, 56'h9C_01_01_0000A00_1, 56'h9C_01_01_0000000_0,
    56'hA1_01_00_0001000_1, 56'hA1_01_00_0002000_0, 56'hA1_02_00_0002000_1,
    56'hA1_40_00_0040000_1, 56'hA1_80_00_0080000_1, 56'hA1_04_00_0004000_1,
    56'hA1_08_00_0008000_1, 56'hA1_0C_00_000C000_1, 56'hA1_10_00_0010000_1,
    56'hA1_20_00_0020000_1, 56'hA1_30_00_0030000_1, 56'hA2_01_00_0100000_1,
    56'hA2_04_00_0200000_1, 56'hA2_08_00_0400000_1, 56'hA2_08_00_0C00000_0,
    56'hA2_10_00_1000000_1, 56'hAB_01_00_2000000_1, 56'h88_8C_00_0000091_1,
    56'h88_8C_00_0000011_0, 56'h00_FF_00_3FFFFFF_0, 56'h88_82_00_0000085_1,
    56'h89_88_00_0000191_1, 56'h89_88_00_0000091_0, 56'h9C_01_04_0000A00_1,
    56'h9C_01_06_0000A00_0, 56'h9C_01_00_0000E00_7, 56'h9C_02_00_0000A00_0,
    56'hAB_03_00_2000000_0
  };
  bds_core_model u_core (.clk(pclk), .vec(vec), .ev(ev));
  bds_event_select DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .br_valid(ev[0]), .br_cond(ev[1]), .br_direct_jmp(ev[2]), .br_indirect_jmp(ev[3]),
    .br_return(ev[4]), .br_direct_call(ev[5]), .br_indirect_call(ev[6]), .br_taken(ev[7]),
    .br_mispredicted(ev[8]), .undelivered_slots(ev[11:9]), .disp_p0(ev[12]),
    .disp_p1(ev[13]), .disp_p2_load(ev[14]), .disp_p2_store_address_uop(ev[15]),
    .disp_p3_load(ev[16]), .disp_p3_store_address_uop(ev[17]), .disp_p4(ev[18]),
    .disp_p5(ev[19]), .stall_any(ev[20]), .stall_reservation_station(ev[21]),
    .stall_store_buffer(ev[22]), .stall_store_buffer_drain(ev[23]),
    .stall_reorder_buffer(ev[24]), .decode_path_switch(ev[25]),
    .event_count, .event_increment
  );
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Strobes for one cycle, then settle before looking
  task automatic pulse(input logic [25:0] s);
    vec <= s;
    @(posedge pclk);
    vec <= 26'h0000000;
    @(negedge pclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    fails++;
    give_verdict;
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    presetn = 1'b0;
    vec = 26'h0000000;
    exp_cnt = 32'h00000000;
    fails = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    check(event_count, 32'h00000000);
    check({31'h0, pready}, 32'h00000001);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h00000000, rd, err);
    check(rd, 32'h00000000);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, {rows[i][39:32], 7'h00, 1'b1, rows[i][47:40], rows[i][55:48]}, rd, err);
      pulse(rows[i][29:4]);
      exp_cnt = exp_cnt + {29'h0, rows[i][2:0]};
      check({29'h0, event_increment}, {29'h0, rows[i][2:0]});
      check(event_count, exp_cnt);
      $display("row %0d done", i);
    end
    apb(1'b1, 8'h00, 32'h0000FF88, rd, err);
    pulse(26'h0000089);
    check({29'h0, event_increment}, 32'h00000000);
    // Preset to all ones so one switch has to wrap
    apb(1'b1, 8'h04, 32'hFFFFFFFF, rd, err);
    apb(1'b0, 8'h04, 32'h00000000, rd, err);
    check(rd, 32'hFFFFFFFF);
    apb(1'b1, 8'h00, 32'h000101AB, rd, err);
    pulse(26'h2000000);
    check(event_count, 32'h00000000);
    // Wrap leaves the sticky flag up until software writes one to it
    apb(1'b0, 8'h08, 32'h00000000, rd, err);
    check(rd, 32'h00010001);
    check({31'h0, err}, 32'h00000000);
    apb(1'b1, 8'h08, 32'h00000001, rd, err);
    apb(1'b0, 8'h08, 32'h00000000, rd, err);
    check(rd, 32'h00010000);
    apb(1'b0, 8'h0C, 32'h00000000, rd, err);
    check({31'h0, err}, 32'h00000001);
    check(rd, 32'h00000000);
    $display("preset and unmapped done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check(event_count, 32'h00000000);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h00000000, rd, err);
    check(rd, 32'h00000000);
    $display("mid-run reset done");
    give_verdict;
  end
endmodule // bds_event_select_tb
`default_nettype wire
